// [rtl/srl_cfg.svh]
`ifndef SRL_CFG_SVH
`define SRL_CFG_SVH
// Word format
`define SRL_WORD_BITS      24
`define SRL_SEL_MSB        3
`define SRL_SEL_LSB        0
`define SRL_PAY_MSB        23
`define SRL_PAY_LSB        4
`define SRL_MAIN_PAY_LSB   1
`define SRL_NUM_REGS       8
// Reset values of held registers
`define SRL_PAY_RESET      20'h0_0000
`define SRL_MAIN_RESET     23'h00_0000
`define SRL_WORD_RESET     24'h00_0000
`endif

// [rtl/srl_loader.sv]
`include "srl_cfg.svh"
`default_nettype none
module srl_loader (
  input  wire logic                  core_clk,          // 100 MHz clock
  input  wire logic                  reset_n,           // Sync reset, low
  input  wire logic                  link_clk,          // Serial clock pin
  input  wire logic                  link_data,         // Serial data pin
  input  wire logic                  latch_strobe,      // Latch strobe pin
  output logic [22:0]                main_divider_register, // Register 0
  output wire logic [7*20-1:0]       cfg_regs,          // Regs 1..7 packed
  output logic [`SRL_NUM_REGS-1:0]   load_pulse,        // Per-reg load
  output logic                       counter_reset      // Lock/fastlock rst
);
  // Two-stage synchronisers for the three pins
  srl_pkg::srl_link_t s1_q;
  srl_pkg::srl_link_t s2_q;
  srl_pkg::srl_link_t s3_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= '{clk: link_clk, data: link_data, latch: latch_strobe};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge detection on synchronised copies only
  logic clk_rise;
  logic latch_rise;
  assign clk_rise   = s2_q.clk & ~s3_q.clk;
  assign latch_rise = s2_q.latch & ~s3_q.latch;

  // Shift register, MSB first
  logic [`SRL_WORD_BITS-1:0] shift_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shift_q <= `SRL_WORD_RESET;
    end else if (clk_rise) begin
      shift_q <= {shift_q[`SRL_WORD_BITS-2:0], s2_q.data};
    end
  end

  // Destination decode from the select field
  logic [3:0] sel;
  logic [2:0] dest;
  assign sel  = shift_q[`SRL_SEL_MSB:`SRL_SEL_LSB];
  assign dest = sel[0] ? sel[3:1] : 3'h0;

  // Register 0 load, counter reset pulse
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      main_divider_register <= `SRL_MAIN_RESET;
      counter_reset         <= 1'b0;
    end else begin
      counter_reset <= latch_rise && (dest == 3'h0);
      if (latch_rise && dest == 3'h0) begin
        main_divider_register <=
          shift_q[`SRL_PAY_MSB:`SRL_MAIN_PAY_LSB];
      end
    end
  end

  // Registers 1 to 7; select 0001 decodes to register 0, nothing is lost
  // Each slot owns its flops, so no variable has two writing processes
  genvar gi;
  generate
    for (gi = 1; gi < `SRL_NUM_REGS; gi++) begin : g_reg
      logic [19:0] pay_q;
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          pay_q <= `SRL_PAY_RESET;
        end else if (latch_rise && dest == 3'(gi)) begin
          pay_q <= shift_q[`SRL_PAY_MSB:`SRL_PAY_LSB];
        end
      end
      // Slot joined onto the packed output net
      assign cfg_regs[(gi-1)*20 +: 20] = pay_q;

      // Slot takes the payload of a word that selects it
      a_slot_load: assert property (@(posedge core_clk)
        disable iff (!reset_n)
        latch_rise && dest == 3'(gi) |=>
        pay_q == $past(shift_q[23:4]))
        else $error("slot load wrong");
    end
  endgenerate

  // Load strobes, one per destination
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      load_pulse <= '0;
    end else begin
      load_pulse <= latch_rise ? (8'h01 << dest) : 8'h00;
    end
  end

  // Checks
  a_main_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    latch_rise && !shift_q[0] |=> counter_reset &&
    main_divider_register == $past(shift_q[23:1]))
    else $error("main register load wrong");
  a_no_shift_write: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    !latch_rise |=> $stable(main_divider_register) && $stable(cfg_regs))
    else $error("register changed without strobe");
  a_reg7_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    latch_rise && shift_q[3:0] == 4'hf |=>
    cfg_regs[139:120] == $past(shift_q[23:4]) && !counter_reset)
    else $error("register 7 load wrong");
  a_reg1_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    latch_rise && shift_q[3:0] == 4'h3 |=>
    cfg_regs[19:0] == $past(shift_q[23:4]) && load_pulse == 8'h02)
    else $error("register 1 load wrong");
  a_shift_msb: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_rise |=> shift_q[0] == $past(s2_q.data) &&
    shift_q[23:1] == $past(shift_q[22:0]))
    else $error("shift order wrong");
  a_shift_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !clk_rise |=> $stable(shift_q))
    else $error("shift without clock edge");
  a_sel_dest: assert property (@(posedge core_clk) disable iff (!reset_n)
    latch_rise && shift_q[0] |=> load_pulse == (8'h01 << $past(sel[3:1])))
    else $error("select decode wrong");
  a_strobe_cause: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    counter_reset |-> $past(latch_rise))
    else $error("counter reset without strobe");

  // Further checks on the load path
  // The strobe edge is one cycle wide, so every output pulse is too
  // Register 0 and the other slots never disturb one another
  // A host that misses a serial edge leaves old bits in the word;
  // that is its fault and not flagged here, only the device side is
  // Reset clears every output within one edge
  // These hold on the synchronised view, two to three cycles behind
  // the pins, which is the price of safe pin sampling

  // Reset leaves every output cleared
  a_reset_clear: assert property (@(posedge core_clk)
    !reset_n |=> main_divider_register == '0 && cfg_regs == '0 &&
    load_pulse == '0 && !counter_reset)
    else $error("outputs not cleared by reset");

  // At most one destination per strobe
  a_pulse_onehot: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    load_pulse != 8'h00 |-> $onehot(load_pulse))
    else $error("more than one load pulse");

  // Load strobe lasts a single cycle
  a_pulse_single: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    load_pulse != 8'h00 |=> load_pulse == 8'h00)
    else $error("load pulse too long");

  // Counter reset goes with the register 0 strobe
  a_cr_with_main: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    counter_reset == load_pulse[0])
    else $error("counter reset without register 0 load");

  // Counter reset is a single-cycle pulse
  a_cr_single: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    counter_reset |=> !counter_reset)
    else $error("counter reset too long");

  // A register 0 load leaves the other slots alone
  a_main_isolated: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    latch_rise && dest == 3'h0 |=> $stable(cfg_regs))
    else $error("register 0 load touched others");

  // A slot load leaves register 0 and the counters alone
  a_slot_isolated: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    latch_rise && dest != 3'h0 |=>
    $stable(main_divider_register) && !counter_reset)
    else $error("slot load touched register 0");

  // Select 0001 is still a register 0 write
  a_sel_one_main: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    latch_rise && shift_q[3:0] == 4'h1 |=> counter_reset)
    else $error("select 0001 not sent to register 0");

  // Upper select bits ignored while bit zero is low
  a_sel_even_main: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    latch_rise && shift_q[3:0] == 4'h8 |=> load_pulse == 8'h01)
    else $error("select 1000 not sent to register 0");

  // Serial clock edge seen for one cycle only
  a_clk_edge_single: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    clk_rise |=> !clk_rise)
    else $error("serial edge seen twice");

  // Strobe edge seen for one cycle only
  a_latch_single: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    latch_rise |=> !latch_rise)
    else $error("strobe edge seen twice");

  // New bit enters at the bottom of the word
  a_data_taken: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    clk_rise |=> shift_q[0] == $past(s2_q.data))
    else $error("serial bit not taken");

  // Register 0 holds between its own loads
  a_main_hold: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    !(latch_rise && dest == 3'h0) |=> $stable(main_divider_register))
    else $error("register 0 changed without its strobe");

  // Decode never picks a slot when bit zero is low
  a_dest_zero: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    !sel[0] |-> dest == 3'h0)
    else $error("decode ignored select bit zero");
endmodule : srl_loader
`default_nettype wire

// [rtl/srl_pkg.sv]
`include "srl_cfg.svh"
`default_nettype none
package srl_pkg;
  // Payload of registers 1 to 7
  typedef logic [19:0] srl_pay_t;
  // Payload of the main divider register
  typedef logic [22:0] srl_main_t;
  // Serial link pins after synchronisation
  typedef struct packed {
    logic clk;
    logic data;
    logic latch;
  } srl_link_t;
endpackage : srl_pkg
`default_nettype wire

// [testbench/serial_register_loader_test.sv]
`default_nettype none
module serial_register_loader_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic         core_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         link_clk, link_data, latch_strobe, counter_reset;
  logic [22:0]  main_reg;
  logic [139:0] cfg_regs, exp_cfg;
  logic [7:0]   load_pulse;
  int           n_fail = 0;
  int           checks = 0;
  int           n_cr = 0;
  logic [7:0]   last_lp = 8'h00;
  always #5 core_clk = ~core_clk;
  srl_host_model host (.core_clk(core_clk), .link_clk(link_clk),
    .link_data(link_data), .latch_strobe(latch_strobe));
  srl_loader dut (.core_clk(core_clk), .reset_n(reset_n),
    .link_clk(link_clk), .link_data(link_data),
    .latch_strobe(latch_strobe), .main_divider_register(main_reg),
    .cfg_regs(cfg_regs), .load_pulse(load_pulse),
    .counter_reset(counter_reset));
  // Pulse lasts one cycle, so count it as it passes
  always @(negedge core_clk) if (counter_reset === 1'b1) n_cr++;
  // Last load strobe seen, sampled away from its launching edge
  always @(negedge core_clk) if (load_pulse !== 8'h00) last_lp = load_pulse;
  task automatic cmp(input logic [139:0] got, input logic [139:0] exp);
    checks++;
    if (got !== exp) begin
      $display("BAD %0t got %h want %h", $time, got, exp);
      n_fail++;
    end
  endtask : cmp
  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Each select code 1..7 lands in its own slot only
  task automatic t_select();
    logic [19:0] p;
    logic [7:0]  lp_exp;
    exp_cfg = '0;
    for (int k = 1; k < 8; k++) begin
      p = 20'hA_5C30 + 20'(k);
      exp_cfg[(k-1)*20 +: 20] = p;
      lp_exp = 8'h01 << k[2:0];
      host.send({p, k[2:0], 1'b1}, 1'b1);
      cmp(cfg_regs, exp_cfg);
      cmp(140'(main_reg), '0);
      cmp(140'(last_lp), 140'(lp_exp));
    end
    $display("t_select done");
  endtask : t_select
  // Shifting without a strobe changes nothing
  task automatic t_shift();
    host.send(24'h0F_FFF3, 1'b0);
    cmp(cfg_regs, exp_cfg);
    $display("t_shift done");
  endtask : t_shift
  // Main divider written last; select bits 3..1 set but bit 0 clear
  task automatic t_main();
    host.send(24'hA5_3C4E, 1'b1);
    cmp(140'(main_reg), 140'(23'h52_9E27));
    cmp(140'(n_cr), 140'd1);
    cmp(cfg_regs, exp_cfg);
    cmp(140'(last_lp), 140'(8'h01));
    $display("t_main done");
  endtask : t_main
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmp(cfg_regs, '0);
    cmp(140'(main_reg), '0);
    cmp(140'(load_pulse), '0);
    t_select();
    t_shift();
    t_main();
    final_report();
  end
  // Watchdog well past the ~40 us the tests need
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule : serial_register_loader_test
`default_nettype wire

// [testbench/srl_host_model.sv]
`default_nettype none
module srl_host_model (
  input  wire logic core_clk,    // Bench clock
  output logic      link_clk,    // Serial clock
  output logic      link_data,   // Serial data
  output logic      latch_strobe // Latch strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // One word, 16-cycle bit period; strobe optional to test bare shifting
  task automatic send(input logic [23:0] w, input logic le);
    for (int i = 23; i >= 0; i--) begin
      @(posedge core_clk) link_data <= w[i];
      repeat (4) @(posedge core_clk);
      link_clk <= 1'b1;
      repeat (8) @(posedge core_clk);
      link_clk <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    @(posedge core_clk) link_data <= ~w[0]; // No stale bit left
    latch_strobe <= le;
    repeat (16) @(posedge core_clk);
    latch_strobe <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : send
endmodule : srl_host_model
`default_nettype wire
